// ==== rtl/rst_wake_pkg.sv ====
// constants and types for the reset and wake-up state loader
// assumes one 50 MHz clock; registers are reached over APB
// ------------------------------------------------------------
// ------------------------------------------------------------
package rst_wake_pkg;
  // ----------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------
  localparam logic [7:0] ptr1_high_byte_off = 8'h00;
  localparam logic [7:0] ptr1_low_byte_off = 8'h04;
  localparam logic [7:0] bank_select_off = 8'h08;
  localparam logic [7:0] ptr2_high_byte_off = 8'h0C;
  localparam logic [7:0] ptr2_low_byte_off = 8'h10;
  localparam logic [7:0] arith_flags_off = 8'h14;
  localparam logic [7:0] timer0_count_high_off = 8'h18;
  localparam logic [7:0] timer0_count_low_off = 8'h1C;
  localparam logic [7:0] timer0_control_off = 8'h20;
  localparam logic [7:0] clock_source_select_off = 8'h24;
  localparam logic [7:0] lvd_control_off = 8'h28;
  localparam logic [7:0] watchdog_soft_enable_off = 8'h2C;
  localparam logic [7:0] reset_cause_flags_off = 8'h30;
  localparam logic [7:0] timer1_count_high_off = 8'h34;
  localparam logic [7:0] timer1_count_low_off = 8'h38;
  localparam logic [7:0] timer1_control_off = 8'h3C;
  localparam logic [7:0] timer2_count_off = 8'h40;
  localparam logic [7:0] timer2_period_off = 8'h44;
  localparam logic [7:0] timer2_control_off = 8'h48;
  localparam logic [7:0] serial_port_buffer_off = 8'h4C;
  localparam logic [7:0] serial_port_address_baud_off = 8'h50;
  localparam logic [7:0] serial_port_flags_off = 8'h54;
  localparam logic [7:0] serial_port_control_a_off = 8'h58;
  localparam logic [7:0] serial_port_control_b_off = 8'h5C;
  localparam logic [7:0] stack_top_upper_off = 8'h60;
  localparam logic [7:0] stack_top_high_off = 8'h64;
  localparam logic [7:0] stack_top_low_off = 8'h68;
  localparam logic [7:0] return_stack_pointer_off = 8'h6C;
  localparam logic [7:0] port_a_data_off = 8'h70;
  localparam logic [7:0] port_a_latch_off = 8'h74;
  localparam logic [7:0] port_a_direction_off = 8'h78;
  localparam logic [7:0] interrupt_control_off = 8'h7C;
  localparam logic [7:0] osc_mode_off = 8'h80;
  localparam logic [7:0] program_counter_off = 8'h84;
  localparam logic [7:0] peripheral_int_flag_off = 8'h88;
  // ----------------------------------------------------------
  // implemented-bit masks and reset patterns
  // ----------------------------------------------------------
  localparam logic [7:0] mask4 = 8'h0F;
  localparam logic [7:0] mask5 = 8'h1F;
  localparam logic [7:0] mask6 = 8'h3F;
  localparam logic [7:0] mask1 = 8'h01;
  localparam logic [7:0] t1_mask = 8'hBF;
  localparam logic [7:0] t2_mask = 8'h7F;
  localparam logic [7:0] reset_cause_flags_mask = 8'hDF;
  localparam logic [7:0] return_stack_pointer_mask = 8'hDF;
  localparam logic [7:0] port_a_mask = 8'h7F;
  localparam logic [7:0] zero_rst = 8'h00;
  localparam logic [7:0] ones_rst = 8'hFF;
  localparam logic [7:0] lvd_rst = 8'h05;
  // reset cause flag fields
  localparam int reset_cause_flags_bor_bit = 0;
  localparam int reset_cause_flags_por_bit = 1;
  localparam int reset_cause_flags_pd_bit = 2;
  localparam int reset_cause_flags_to_bit = 3;
  localparam int reset_cause_flags_ri_bit = 4;
  localparam int reset_cause_flags_lwrt_bit = 6;
  localparam int reset_cause_flags_ipen_bit = 7;
  localparam int port_a_io_bit = 6;
  // interrupt control fields
  localparam int high_priority_global_int_enable_bit = 7;
  localparam int low_priority_global_int_enable_bit = 6;
  localparam int wake_flag_bit = 0;
  // stack pointer fields
  localparam int stk_full_bit = 7;
  localparam int stk_unf_bit = 6;
  // ----------------------------------------------------------
  // vectors and widths
  // ----------------------------------------------------------
  localparam int pc_width = 21;
  localparam logic [20:0] high_vector = 21'h000008;
  localparam logic [20:0] low_vector = 21'h000018;
  localparam logic [20:0] pc_step = 21'h000002;
  localparam logic [4:0] stack_depth_max = 5'h1F;
  // oscillator mode codes
  localparam logic [2:0] ext_clock_with_io_mode = 3'h5;
  localparam logic [2:0] rc_osc_with_io_mode = 3'h6;

  typedef enum {
    class_none,
    class_por_bor,
    class_master_clear_pin_wdt_sw,
    class_wake
  } reset_class_t;

  typedef struct packed {
    logic por;
    logic bor;
    logic master_clear_pin;
    logic wdt_reset;
    logic soft_reset;
    logic stack_reset;
    logic wdt_wake;
    logic int_wake;
    logic high_pri;
  } reset_events_t;
endpackage : rst_wake_pkg

// ==== rtl/reset_wake_state_logic.sv ====
// reset and wake-up state loader with APB register access
// assumes reset event pulses synchronous to pclk, one per cycle at most
//
// The APB register port and the placing of the registers were left to the implementer.
module reset_wake_state_logic
  import rst_wake_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // reset and wake events, one-cycle pulses
  input wire reset_events_t events,
  // state seen by the core
  output logic [20:0] program_counter,
  output logic [4:0] stack_depth
);
  // ----------------------------------------------------------
  // register storage
  // ----------------------------------------------------------
  logic [7:0] regs [0:34];
  logic [20:0] pc;
  reset_class_t cls;
  logic int_vec_wake;

  function automatic logic [7:0] impl_mask(input logic [5:0] idx, input logic [2:0] osc);
    case (idx)
      6'd0, 6'd2, 6'd3: impl_mask = mask4;
      6'd5: impl_mask = mask5;
      6'd9, 6'd11: impl_mask = mask1;
      6'd10: impl_mask = mask6;
      6'd12: impl_mask = reset_cause_flags_mask;
      6'd15: impl_mask = t1_mask;
      6'd18: impl_mask = t2_mask;
      6'd24: impl_mask = mask5;
      6'd27: impl_mask = return_stack_pointer_mask;
      6'd32: impl_mask = 8'h07;
      6'd28, 6'd29, 6'd30:
        // bit 7 of port a is never there; bit 6 only in the two io modes
        impl_mask = (osc == ext_clock_with_io_mode || osc == rc_osc_with_io_mode) ?
                    port_a_mask : mask6;
      default: impl_mask = ones_rst;
    endcase
  endfunction : impl_mask

  // ----------------------------------------------------------
  // event decode
  // ----------------------------------------------------------
  wire logic any_por = events.por | events.bor;
  wire logic any_mid = events.master_clear_pin | events.wdt_reset | events.soft_reset | events.stack_reset;
  wire logic any_wake = events.wdt_wake | events.int_wake;
  // priority: power-on class over master-clear class over wake-up
  assign cls = any_por ? class_por_bor : any_mid ? class_master_clear_pin_wdt_sw : any_wake ? class_wake : class_none;
  wire logic [7:0] intc = regs[31];
  assign int_vec_wake = events.int_wake && (intc[high_priority_global_int_enable_bit] || intc[low_priority_global_int_enable_bit]) && !any_por && !any_mid;
  wire logic [4:0] sp = regs[27][4:0];

  // apb decode
  wire logic [5:0] idx = paddr[7:2];
  wire logic hit = (paddr[1:0] == 2'b00) && (idx <= 6'd34);
  wire logic access = psel && penable;
  wire logic do_write = access && pwrite && hit;
  wire logic [7:0] rd_mask = impl_mask(idx, regs[32][2:0]);
  wire logic [31:0] pc_word = {11'h000, pc};

  assign pready = 1'b1;
  assign pslverr = access && !hit;
  assign program_counter = pc;
  assign stack_depth = sp;

  // read data: unimplemented bits forced low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      if (!hit) begin
        prdata <= 32'h00000000;
      end else if (idx == 6'd33) begin
        prdata <= pc_word;
      end else begin
        prdata <= {24'h000000, regs[idx] & rd_mask};
      end
    end
  end

  // ----------------------------------------------------------
  // program counter
  // ----------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc <= 21'h000000;
    end else if (cls == class_por_bor || cls == class_master_clear_pin_wdt_sw) begin
      pc <= 21'h000000;
    end else if (int_vec_wake) begin
      pc <= events.high_pri ? high_vector : low_vector;
    end else if (cls == class_wake) begin
      pc <= pc + pc_step;
    end else if (do_write && idx == 6'd33) begin
      pc <= pwdata[20:0];
    end
  end

  // ----------------------------------------------------------
  // per-register reset patterns
  // ----------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 35; i++) begin
        regs[i] <= zero_rst;
      end
      regs[8] <= ones_rst;
      regs[10] <= lvd_rst;
      regs[17] <= ones_rst;
      regs[12] <= 8'h1E;
    end else begin
      if (do_write && idx != 6'd33) begin
        regs[idx] <= pwdata[7:0] & impl_mask(idx, regs[32][2:0]);
      end
      case (cls)
        class_por_bor: begin
          // unknown bits on power-on keep whatever they hold
          regs[0] <= zero_rst;
          regs[2] <= zero_rst;
          regs[3] <= zero_rst;
          regs[8] <= ones_rst;
          regs[9] <= zero_rst;
          regs[10] <= lvd_rst;
          regs[11] <= zero_rst;
          regs[15] <= zero_rst;
          regs[17] <= ones_rst;
          for (int i = 18; i < 24; i++) begin
            if (i != 19) begin
              regs[i] <= zero_rst;
            end
          end
          for (int i = 24; i < 28; i++) begin
            regs[i] <= zero_rst;
          end
          regs[31] <= zero_rst;
          // brown-out alone keeps the long write enable as it was
          regs[12] <= {1'b0, events.por ? 1'b0 : regs[12][reset_cause_flags_lwrt_bit], 1'b0, 1'b1, 1'b1, 1'b1,
                       events.por ? 1'b0 : 1'b1, 1'b0};
        end
        class_master_clear_pin_wdt_sw: begin
          regs[0] <= zero_rst;
          regs[2] <= zero_rst;
          regs[3] <= zero_rst;
          regs[8] <= ones_rst;
          regs[9] <= zero_rst;
          regs[10] <= lvd_rst;
          regs[11] <= zero_rst;
          regs[17] <= ones_rst;
          for (int i = 18; i < 24; i++) begin
            if (i != 19) begin
              regs[i] <= zero_rst;
            end
          end
          for (int i = 24; i < 28; i++) begin
            regs[i] <= zero_rst;
          end
          regs[31] <= zero_rst;
          regs[27][stk_full_bit] <= events.stack_reset ? regs[27][stk_full_bit] : 1'b0;
          // long write enable survives every class except por and master_clear_pin
          regs[12][reset_cause_flags_lwrt_bit] <= events.master_clear_pin ? 1'b0 : regs[12][reset_cause_flags_lwrt_bit];
          regs[12][reset_cause_flags_ipen_bit] <= 1'b0;
          regs[12][reset_cause_flags_ri_bit] <= !events.soft_reset;
          regs[12][reset_cause_flags_to_bit] <= !events.wdt_reset;
          regs[12][reset_cause_flags_pd_bit] <= 1'b1;
        end
        class_wake: begin
          regs[17] <= ones_rst;
          regs[12][reset_cause_flags_to_bit] <= !events.wdt_wake;
          regs[12][reset_cause_flags_pd_bit] <= 1'b0;
          // a flag records the cause of the wake
          regs[34][wake_flag_bit] <= 1'b1;
          if (events.wdt_wake) begin
            regs[31][wake_flag_bit] <= 1'b1;
          end
          if (int_vec_wake) begin
            regs[24] <= {3'b000, pc[20:16]};
            regs[25] <= pc[15:8];
            regs[26] <= pc[7:0];
            if (sp == stack_depth_max) begin
              regs[27][stk_full_bit] <= 1'b1;
            end else begin
              regs[27][4:0] <= sp + 5'h01;
            end
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------
  // checks
  // ----------------------------------------------------------
  sequence vec_wake_s;
    int_vec_wake && (sp != stack_depth_max);
  endsequence

  property push_p;
    logic [4:0] old_sp;
    logic [20:0] old_pc;
    @(posedge pclk) disable iff (!presetn)
    (vec_wake_s, old_sp = sp, old_pc = pc) |=> (sp == old_sp + 5'h01) && (regs[26] == old_pc[7:0]);
  endproperty

  vector_load_a: assert property (@(posedge pclk) disable iff (!presetn)
    int_vec_wake |=> (pc == high_vector || pc == low_vector))
    else $error("wake did not load a vector");
  stack_push_a: assert property (push_p)
    else $error("stack not pushed on vectored wake");
  stack_ptr_a: assert property (@(posedge pclk) disable iff (!presetn)
    vec_wake_s |=> sp == $past(sp) + 5'h01)
    else $error("stack pointer not advanced");
  wake_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    (cls == class_wake) |=> regs[34][wake_flag_bit])
    else $error("wake cause flag not set");
  port_bit_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && hit && idx >= 6'd28 && idx <= 6'd30 && regs[32][2:0] != ext_clock_with_io_mode
     && regs[32][2:0] != rc_osc_with_io_mode) |=> !prdata[port_a_io_bit])
    else $error("port a bit 6 visible outside io modes");
  lwrt_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    (any_mid && !events.master_clear_pin && !any_por && !do_write) |=> $stable(regs[12][reset_cause_flags_lwrt_bit]))
    else $error("long write enable changed by other reset");
  unimpl_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && idx == 6'd9) |=> prdata[31:1] == 31'h0)
    else $error("unimplemented bits read nonzero");
  period_ones_a: assert property (@(posedge pclk) disable iff (!presetn)
    (cls != class_none) |=> regs[17] == ones_rst)
    else $error("timer2 period not forced to ones");
endmodule : reset_wake_state_logic

// ==== bench/reset_wake_state_logic_tb.sv ====
// self-checking bench for the reset and wake-up state loader
// assumes the design answers apb with zero wait states and event pulses of one cycle
module reset_wake_state_logic_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import rst_wake_pkg::*;
  // ----------------------------------------------------------
  // signals
  // ----------------------------------------------------------
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic err;
  reset_events_t events, ev;
  logic [20:0] program_counter;
  logic [4:0] stack_depth;
  int error_cnt = 0;
  int num_checks = 0;
  typedef struct {logic [7:0] a; logic [31:0] rst; logic [31:0] wd; logic [31:0] rb;} row_t;
  row_t rows [14] = '{
    '{8'h00, 32'h00, 32'hFF, 32'h0F}, '{8'h08, 32'h00, 32'hFF, 32'h0F},
    '{8'h14, 32'h00, 32'hFF, 32'h1F}, '{8'h20, 32'hFF, 32'h00, 32'h00},
    '{8'h24, 32'h00, 32'hFF, 32'h01}, '{8'h28, 32'h05, 32'h05, 32'h05},
    '{8'h2C, 32'h00, 32'hFF, 32'h01}, '{8'h3C, 32'h00, 32'hFF, 32'hBF},
    '{8'h44, 32'hFF, 32'h10, 32'h10}, '{8'h48, 32'h00, 32'hFF, 32'h7F},
    '{8'h50, 32'h00, 32'hA5, 32'hA5}, '{8'h5C, 32'h00, 32'h5A, 32'h5A},
    '{8'h8C, 32'h00, 32'hFF, 32'h00}, '{8'h02, 32'h00, 32'hFF, 32'h00}};

  reset_wake_state_logic DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .events(events), .program_counter(program_counter), .stack_depth(stack_depth));

  // ----------------------------------------------------------
  // tasks
  // ----------------------------------------------------------
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // request held until pready is seen high at a rising edge or 51 edges have passed
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && n++ < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  task pulse(input reset_events_t e);
    @(posedge pclk);
    events <= e;
    @(posedge pclk);
    events <= '0;
    @(posedge pclk);
    #1;
  endtask : pulse

  task close_out;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : close_out

  // ----------------------------------------------------------
  // clock, watchdog, sequence
  // ----------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  initial begin
    #(4000 * 20);
    error_cnt++;
    close_out();
  end

  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; events = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      apb(1'b0, rows[i].a, 32'h0);
      chk("reset value", rows[i].rst, rd);
      chk("slave error", {31'h0, (rows[i].a > 8'h88) || (rows[i].a[1:0] != 2'b00)}, {31'h0, err});
      apb(1'b1, rows[i].a, rows[i].wd);
      apb(1'b0, rows[i].a, 32'h0);
      chk("readback", rows[i].rb, rd);
    end
    apb(1'b0, 8'h30, 32'h0);
    chk("cause flags reset", 32'h1E, rd);
    // every oscillator mode, bit 6 of port a only in the two io modes
    for (int m = 0; m < 8; m++) begin
      apb(1'b1, 8'h80, m);
      apb(1'b1, 8'h74, 32'hFF);
      apb(1'b0, 8'h74, 32'h0);
      chk("port a latch", (m == 5 || m == 6) ? 32'h7F : 32'h3F, rd);
      apb(1'b1, 8'h78, 32'hFF);
      apb(1'b0, 8'h78, 32'h0);
      chk("port a direction", (m == 5 || m == 6) ? 32'h7F : 32'h3F, rd);
    end
    // high priority wake with enable set
    apb(1'b1, 8'h84, 32'h012345);
    apb(1'b1, 8'h7C, 32'h80);
    ev = '0; ev.int_wake = 1'b1; ev.high_pri = 1'b1;
    pulse(ev);
    chk("pc high vector", 32'h08, {11'h0, program_counter});
    chk("depth one", 32'h01, {27'h0, stack_depth});
    apb(1'b0, 8'h60, 32'h0);
    chk("stack upper", 32'h01, rd);
    apb(1'b0, 8'h64, 32'h0);
    chk("stack high", 32'h23, rd);
    apb(1'b0, 8'h68, 32'h0);
    chk("stack low", 32'h45, rd);
    apb(1'b0, 8'h88, 32'h0);
    chk("wake flag", 32'h01, rd & 32'h01);
    apb(1'b0, 8'h44, 32'h0);
    chk("period on wake", 32'hFF, rd);
    // low priority wake pushes the vector just taken
    apb(1'b1, 8'h7C, 32'h40);
    ev.high_pri = 1'b0;
    pulse(ev);
    chk("pc low vector", 32'h18, {11'h0, program_counter});
    chk("depth two", 32'h02, {27'h0, stack_depth});
    apb(1'b0, 8'h68, 32'h0);
    chk("stack low second", 32'h08, rd);
    // watchdog wake, no vector and no push
    apb(1'b1, 8'h7C, 32'h00);
    ev = '0; ev.wdt_wake = 1'b1;
    pulse(ev);
    chk("pc plus two", 32'h1A, {11'h0, program_counter});
    chk("depth kept", 32'h02, {27'h0, stack_depth});
    apb(1'b0, 8'h7C, 32'h0);
    chk("wdt wake flag", 32'h01, rd & 32'h01);
    // long write enable survives every reset but power-on and master clear
    apb(1'b1, 8'h30, 32'h5E);
    ev = '0; ev.bor = 1'b1;
    pulse(ev);
    apb(1'b0, 8'h30, 32'h0);
    chk("lwe after bor", 32'h40, rd & 32'h40);
    ev = '0; ev.wdt_reset = 1'b1;
    pulse(ev);
    apb(1'b0, 8'h30, 32'h0);
    chk("lwe after wdt", 32'h40, rd & 32'h40);
    ev = '0; ev.master_clear_pin = 1'b1;
    pulse(ev);
    apb(1'b0, 8'h30, 32'h0);
    chk("lwe after master_clear_pin", 32'h00, rd & 32'h40);
    close_out();
  end
endmodule : reset_wake_state_logic_tb
